/* File: design/spi_pkg.sv */
`default_nettype none

package spi_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_ADDR   = 8'hf8;
   localparam logic [7:0] DATA_ADDR   = 8'hf7;
   localparam logic [7:0] CTRL_RESET  = 8'h04;
   localparam logic [7:0] DATA_RESET  = 8'h00;

   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int DONE_BIT    = 7;
   localparam int COLLISION_BIT = 6;
   localparam int ENABLE_BIT  = 5;
   localparam int MASTER_BIT  = 4;
   localparam int IDLE_LEVEL_SELECT_BIT    = 3;
   localparam int EDGE_PHASE_SELECT_BIT    = 2;
   localparam int RATE_HI_BIT = 1;
   localparam int RATE_LO_BIT = 0;

   // ----------------------------------------
   // Byte framing counts
   // ----------------------------------------
   localparam int         BYTE_BITS = 8;
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [3:0] LAST_BIT  = 4'h7;
   localparam logic [3:0] FULL_BYTE = 4'h8;

   typedef struct packed {
      logic       enable;
      logic       master;
      logic       idle_level_select;
      logic       edge_phase_select;
      logic [1:0] rate;
   } ctrl_type;

   typedef enum {MASTER_IDLE, MASTER_RUN} master_state_type;

endpackage

`default_nettype wire

/* File: design/spi_control_and_shift.sv */
// How it works
// - Byte end sets transfer done flag bit 7
// - Done flag cleared by zero write or data read
// - Data write while busy sets sticky collision flag
// - Enable bit owns pins, else two-wire interface; alternate pin select also enables two-wire
// - Bit 4 picks master driving clock, slave
// - Bit 3 sets idle clock level
// - Bit 2 picks launch edge, sample opposite
// - Master rate divides by 2,4,8,16
// - Slave reads slave-select level in bit 0
// - Master data write launches eight clock burst
// - Bytes move eight bits, MSB first
// - Slave ends on eighth clock in phase 1, select rise in phase 0
`timescale 1ns/1ns
`default_nettype none

module spi_rx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk_i,
   input  wire logic             reset_n_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two, at least 2");
   end

   assign in_ready_o  = !(wr_ptr[AW] != rd_ptr[AW] && wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign out_valid_o = wr_ptr != rd_ptr;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule // spi_rx_fifo

module spi_control_and_shift #(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   // Register port
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic [7:0] sfr_wdata_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   output var  logic [7:0] sfr_rdata_o,
   // Serial pins
   input  wire logic       sclk_i,
   output logic            sclk_o,
   output logic            sclk_oe_o,
   input  wire logic       mosi_i,
   output logic            mosi_o,
   output logic            mosi_oe_o,
   input  wire logic       miso_i,
   output logic            miso_o,
   output logic            miso_oe_o,
   input  wire logic       slave_select_n_i,
   // Pin sharing
   input  wire logic       alternate_pin_select_i,
   output logic            two_wire_enable_o
);
   spi_pkg::ctrl_type         ctrl;
   spi_pkg::ctrl_type         next_ctrl;
   spi_pkg::master_state_type state;
   spi_pkg::master_state_type next_state;
   logic       done, next_done, collision, next_collision;
   logic [7:0] next_rdata, ctrl_view;
   logic       sclk_s1, sclk_s2, sclk_s3, mosi_s1, mosi_s2;
   logic       miso_s1, miso_s2, ss_s1, ss_s2, ss_s3;
   logic [2:0] div_cnt, next_div_cnt;
   logic [3:0] edge_cnt, next_edge_cnt, s_edge_cnt, next_s_edge_cnt;
   logic [3:0] rx_cnt, next_rx_cnt;
   logic       sclk_q, next_sclk_q, pending, next_pending;
   logic [1:0] samp_d, next_samp_d;
   logic [7:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh, rx_byte, push_data;
   logic       ctrl_wr, ctrl_rd, data_wr, data_rd;
   logic       busy, tick, s_edge, ss_rise, rx_take, rx_bit, complete;
   logic       fifo_ready, fifo_valid;
   logic [7:0] fifo_head;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [2:0] half_limit(input logic [1:0] rate);
      half_limit = 3'((4'd1 << rate) - 4'd1);
   endfunction

   function automatic logic is_sample(input logic edge_phase_select, input logic [3:0] cnt);
      is_sample = cnt[0] == edge_phase_select;
   endfunction

   // First leading edge of phase 1 and last trailing edge of phase 0 do not shift
   function automatic logic is_shift(input logic edge_phase_select, input logic [3:0] cnt);
      is_shift = cnt[0] != edge_phase_select && !(edge_phase_select && cnt == 4'h0)
                 && !(!edge_phase_select && cnt == spi_pkg::LAST_EDGE);
   endfunction

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   always_comb begin
      ctrl_wr = 1'b0;
      ctrl_rd = 1'b0;
      data_wr = 1'b0;
      data_rd = 1'b0;
      if (sfr_addr_i == spi_pkg::CTRL_ADDR) begin
         ctrl_wr = sfr_wr_i;
         ctrl_rd = sfr_rd_i;
      end else if (sfr_addr_i == spi_pkg::DATA_ADDR) begin
         data_wr = sfr_wr_i;
         data_rd = sfr_rd_i;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
         {mosi_s1, mosi_s2, miso_s1, miso_s2} <= 4'h0;
         {ss_s1, ss_s2, ss_s3} <= 3'h7;
      end else begin
         {sclk_s1, sclk_s2, sclk_s3} <= {sclk_i, sclk_s1, sclk_s2};
         {mosi_s1, mosi_s2} <= {mosi_i, mosi_s1};
         {miso_s1, miso_s2} <= {miso_i, miso_s1};
         {ss_s1, ss_s2, ss_s3} <= {slave_select_n_i, ss_s1, ss_s2};
      end
   end

   // ----------------------------------------
   // Shared terms
   // ----------------------------------------
   assign tick     = state == spi_pkg::MASTER_RUN && div_cnt == half_limit(ctrl.rate);
   assign s_edge   = ctrl.enable && !ctrl.master && !ss_s2 && sclk_s2 != sclk_s3;
   assign ss_rise  = ss_s2 && !ss_s3;
   // Master samples two cycles late so MISO has passed its synchroniser
   assign rx_take  = ctrl.master ? samp_d[1] : s_edge && is_sample(ctrl.edge_phase_select, s_edge_cnt);
   assign rx_bit   = ctrl.master ? miso_s2 : mosi_s2;
   assign rx_byte  = {rx_sh[6:0], rx_bit};
   assign complete = ctrl.enable
                     && ((rx_take && rx_cnt == spi_pkg::LAST_BIT && (ctrl.master || ctrl.edge_phase_select))
                     || (!ctrl.master && !ctrl.edge_phase_select && ss_rise
                     && rx_cnt == spi_pkg::FULL_BYTE));
   assign push_data = rx_cnt == spi_pkg::FULL_BYTE ? rx_sh : rx_byte;
   assign busy     = pending || state == spi_pkg::MASTER_RUN || rx_cnt != 4'h0;

   // ----------------------------------------
   // Pins
   // ----------------------------------------
   assign sclk_o            = sclk_q;
   assign sclk_oe_o         = ctrl.enable && ctrl.master;
   assign mosi_o            = tx_sh[7];
   assign mosi_oe_o         = ctrl.enable && ctrl.master;
   assign miso_o            = tx_sh[7];
   assign miso_oe_o         = ctrl.enable && !ctrl.master && !ss_s2;
   assign two_wire_enable_o = !ctrl.enable || alternate_pin_select_i;

   // ----------------------------------------
   // Control and status
   // ----------------------------------------
   always_comb begin
      next_ctrl = ctrl;
      if (ctrl_wr) begin
         next_ctrl.enable = sfr_wdata_i[spi_pkg::ENABLE_BIT];
         next_ctrl.master = sfr_wdata_i[spi_pkg::MASTER_BIT];
         next_ctrl.idle_level_select   = sfr_wdata_i[spi_pkg::IDLE_LEVEL_SELECT_BIT];
         next_ctrl.edge_phase_select   = sfr_wdata_i[spi_pkg::EDGE_PHASE_SELECT_BIT];
         next_ctrl.rate   = {sfr_wdata_i[spi_pkg::RATE_HI_BIT], sfr_wdata_i[spi_pkg::RATE_LO_BIT]};
      end
      // Set wins over clear; writing a one never sets a flag
      next_done = complete
                  || (done && !(ctrl_wr && !sfr_wdata_i[spi_pkg::DONE_BIT]) && !data_rd);
      next_collision = (data_wr && busy)
                  || (collision && !(ctrl_wr && !sfr_wdata_i[spi_pkg::COLLISION_BIT]));
      ctrl_view = 8'h00;
      ctrl_view[spi_pkg::DONE_BIT]    = done;
      ctrl_view[spi_pkg::COLLISION_BIT] = collision;
      ctrl_view[spi_pkg::ENABLE_BIT]  = ctrl.enable;
      ctrl_view[spi_pkg::MASTER_BIT]  = ctrl.master;
      ctrl_view[spi_pkg::IDLE_LEVEL_SELECT_BIT]    = ctrl.idle_level_select;
      ctrl_view[spi_pkg::EDGE_PHASE_SELECT_BIT]    = ctrl.edge_phase_select;
      ctrl_view[spi_pkg::RATE_HI_BIT] = ctrl.rate[1];
      ctrl_view[spi_pkg::RATE_LO_BIT] = ctrl.master ? ctrl.rate[0] : ss_s2;
      next_rdata = sfr_rdata_o;
      if (ctrl_rd) begin
         next_rdata = ctrl_view;
      end else if (data_rd) begin
         next_rdata = fifo_valid ? fifo_head : spi_pkg::DATA_RESET;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl        <= spi_pkg::ctrl_type'(spi_pkg::CTRL_RESET[5:0]);
         done        <= spi_pkg::CTRL_RESET[spi_pkg::DONE_BIT];
         collision   <= spi_pkg::CTRL_RESET[spi_pkg::COLLISION_BIT];
         sfr_rdata_o <= spi_pkg::DATA_RESET;
      end else begin
         ctrl        <= next_ctrl;
         done        <= next_done;
         collision   <= next_collision;
         sfr_rdata_o <= next_rdata;
      end
   end

   // ----------------------------------------
   // Shift engine
   // ----------------------------------------
   always_comb begin
      next_state      = state;
      next_div_cnt    = div_cnt;
      next_edge_cnt   = edge_cnt;
      next_sclk_q     = sclk_q;
      next_pending    = pending;
      next_samp_d     = {samp_d[0], 1'b0};
      next_tx_sh      = tx_sh;
      next_rx_sh      = rx_sh;
      next_rx_cnt     = rx_cnt;
      next_s_edge_cnt = s_edge_cnt;
      case (state)
         spi_pkg::MASTER_IDLE: begin
            next_sclk_q   = ctrl.idle_level_select;
            next_div_cnt  = 3'h0;
            next_edge_cnt = 4'h0;
            // A full receive buffer holds the burst back rather than lose a byte
            if (pending && fifo_ready) begin
               next_state   = spi_pkg::MASTER_RUN;
               next_pending = 1'b0;
            end
         end
         spi_pkg::MASTER_RUN: begin
            if (tick) begin
               next_div_cnt   = 3'h0;
               next_sclk_q    = !sclk_q;
               next_edge_cnt  = edge_cnt + 4'h1;
               next_samp_d[0] = is_sample(ctrl.edge_phase_select, edge_cnt);
               if (is_shift(ctrl.edge_phase_select, edge_cnt)) begin
                  next_tx_sh = {tx_sh[6:0], 1'b0};
               end
               if (edge_cnt == spi_pkg::LAST_EDGE) begin
                  next_state = spi_pkg::MASTER_IDLE;
               end
            end else begin
               next_div_cnt = div_cnt + 3'h1;
            end
         end
         default: next_state = spi_pkg::MASTER_IDLE;
      endcase
      if (ss_s2) begin
         next_s_edge_cnt = 4'h0;
      end else if (s_edge) begin
         next_s_edge_cnt = s_edge_cnt + 4'h1;
         if (is_shift(ctrl.edge_phase_select, s_edge_cnt)) begin
            next_tx_sh = {tx_sh[6:0], 1'b0};
         end
      end
      if (complete || (ss_rise && !ctrl.master)) begin
         next_rx_cnt = 4'h0;
      end else if (rx_take && rx_cnt != spi_pkg::FULL_BYTE) begin
         next_rx_cnt = rx_cnt + 4'h1;
         next_rx_sh  = rx_byte;
      end
      if (data_wr && !busy && ctrl.enable) begin
         next_tx_sh   = sfr_wdata_i;
         next_pending = ctrl.master;
      end
      if (!ctrl.enable || !ctrl.master) begin
         next_state   = spi_pkg::MASTER_IDLE;
         next_pending = 1'b0;
      end
      if (!ctrl.enable) begin
         next_rx_cnt     = 4'h0;
         next_s_edge_cnt = 4'h0;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state      <= spi_pkg::MASTER_IDLE;
         div_cnt    <= 3'h0;
         edge_cnt   <= 4'h0;
         sclk_q     <= spi_pkg::CTRL_RESET[spi_pkg::IDLE_LEVEL_SELECT_BIT];
         pending    <= 1'b0;
         samp_d     <= 2'h0;
         tx_sh      <= spi_pkg::DATA_RESET;
         rx_sh      <= spi_pkg::DATA_RESET;
         rx_cnt     <= 4'h0;
         s_edge_cnt <= 4'h0;
      end else begin
         state      <= next_state;
         div_cnt    <= next_div_cnt;
         edge_cnt   <= next_edge_cnt;
         sclk_q     <= next_sclk_q;
         pending    <= next_pending;
         samp_d     <= next_samp_d;
         tx_sh      <= next_tx_sh;
         rx_sh      <= next_rx_sh;
         rx_cnt     <= next_rx_cnt;
         s_edge_cnt <= next_s_edge_cnt;
      end
   end

   // ----------------------------------------
   // Receive buffer
   // ----------------------------------------
   spi_rx_fifo #(
      .WIDTH(spi_pkg::BYTE_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .in_valid_i (complete),
      .in_ready_o (fifo_ready),
      .in_data_i  (push_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(data_rd),
      .out_data_o (fifo_head)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_done_set: assert property (complete |=> done)
      else $error("done flag not set after byte");
   chk_done_read_clear: assert property (data_rd && !complete |=> !done)
      else $error("data read did not clear done flag");
   chk_collision_set: assert property (data_wr && busy |=> collision)
      else $error("collision flag not set");
   chk_flags_hw_only: assert property (ctrl_wr && sfr_wdata_i[spi_pkg::DONE_BIT] && !done
      && !complete |=> !done)
      else $error("software set the done flag");
   chk_pins_released: assert property (!ctrl.enable |-> !sclk_oe_o && !mosi_oe_o
      && !miso_oe_o && two_wire_enable_o)
      else $error("pins driven while disabled");
   chk_clock_dir: assert property (ctrl.enable && ctrl.master |-> sclk_oe_o && !miso_oe_o)
      else $error("master pin directions wrong");
   chk_idle_level: assert property ((state == spi_pkg::MASTER_IDLE)[*2] ##0 $stable(ctrl.idle_level_select)
      |-> sclk_o == ctrl.idle_level_select)
      else $error("idle clock level wrong");
   chk_first_sample: assert property (tick && edge_cnt == 4'h0 && !ctrl.edge_phase_select
      |=> samp_d[0] ##1 samp_d[1])
      else $error("phase 0 leading edge not sampled");
   chk_rate_quarter: assert property (tick && ctrl.rate == 2'b01 && edge_cnt != 4'hf
      |=> ##1 $stable(sclk_o) ##1 !$stable(sclk_o))
      else $error("divide by four half period wrong");
   chk_ss_readback: assert property (ctrl_rd && !ctrl.master
      |=> sfr_rdata_o[0] == $past(ss_s2))
      else $error("slave select not read back");
   chk_burst_end: assert property ($fell(state == spi_pkg::MASTER_RUN) && ctrl.edge_phase_select
      && ctrl.enable && ctrl.master |-> ##1 complete)
      else $error("burst did not complete the byte");
   chk_msb_first: assert property (data_wr && !busy && ctrl.enable
      |=> mosi_o == $past(sfr_wdata_i[7]))
      else $error("MSB not presented first");
   chk_slave_end: assert property (complete && !ctrl.master && !ctrl.edge_phase_select |-> ss_rise)
      else $error("phase 0 slave ended without select rise");

   cov_master_byte: cover property (complete && ctrl.master);
   cov_slave_byte: cover property (complete && !ctrl.master);
   cov_collision: cover property (data_wr && busy);
   cov_buffer_full: cover property (!fifo_ready && pending);
endmodule // spi_control_and_shift

`default_nettype wire

/* File: sim/spi_peer_model.sv */
`timescale 1ns/1ns
`default_nettype none

module spi_peer_model (
   // Core timing
   input  wire logic       core_clk_i,
   // Frame format
   input  wire logic       idle_level_select_i,
   input  wire logic       edge_phase_select_i,
   // Serial wires
   input  wire logic       sclk_i,
   input  wire logic       din_i,
   output var  logic       dout_o,
   output var  logic       sclk_o,
   output var  logic       ss_n_o,
   // Received byte
   output var  logic [7:0] rx_o
);
   logic [7:0] sh;
   logic       phase;

   // ----------------------------------------
   // Shifter, shared by both roles
   // ----------------------------------------
   // High on the sampling half of each clock period
   assign phase = sclk_i ^ idle_level_select_i ^ edge_phase_select_i;

   initial begin
      dout_o = 1'b0;
      sclk_o = 1'b0;
      ss_n_o = 1'b1;
      rx_o = 8'h00;
      sh = 8'h00;
   end

   always @(posedge phase) begin
      rx_o = {rx_o[6:0], din_i};
   end

   // Filler bits are inverted so a stale line never looks valid
   always @(negedge phase) begin
      if (edge_phase_select_i) begin
         dout_o = sh[7];
         sh = {sh[6:0], ~sh[0]};
      end else begin
         sh = {sh[6:0], ~sh[0]};
         dout_o = sh[7];
      end
   end

   task automatic load(input logic [7:0] b);
      sh = b;
      dout_o = edge_phase_select_i ? ~dout_o : b[7];
   endtask

   // ----------------------------------------
   // Master role: half period of five core cycles
   // ----------------------------------------
   task automatic master_xfer();
      sclk_o = idle_level_select_i;
      ss_n_o = 1'b0;
      repeat (5) @(posedge core_clk_i);
      #1;
      repeat (16) begin
         sclk_o = ~sclk_o;
         repeat (5) @(posedge core_clk_i);
         #1;
      end
      ss_n_o = 1'b1;
   endtask
endmodule // spi_peer_model

`default_nettype wire

/* File: sim/test_spi_control_and_shift.sv */
`timescale 1ns/1ns
`default_nettype none

module test_spi_control_and_shift;
   logic       core_clk_i = 1'b0;
   logic       reset_n_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic       sfr_wr_i = 1'b0;
   logic       sfr_rd_i = 1'b0;
   logic       alternate_pin_select_i = 1'b0;
   logic       pcpol = 1'b0;
   logic       pcpha = 1'b0;
   logic       peer_master = 1'b0;
   logic       tog = 1'b0;
   logic       rd_d = 1'b0;
   logic [15:0] lfsr = 16'h2480;
   logic [7:0] sfr_rdata_o;
   logic       sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, two_wire_enable_o;
   logic       sclk_w, mosi_w, miso_w, peer_din, peer_dout, peer_sclk, peer_ss_n;
   logic [7:0] peer_rx;
   logic [7:0] exp_q[$];
   logic [7:0] exp_rx[0:15];
   logic [7:0] exp_tx[0:15];
   int         n_mismatch = 0;
   int         total_checks = 0;

   // ----------------------------------------
   // Wires, clock and instances
   // ----------------------------------------
   // Undriven data line toggles so a stale bit never matches by luck
   assign sclk_w = sclk_oe_o ? sclk_o : peer_sclk;
   assign mosi_w = mosi_oe_o ? mosi_o : peer_dout;
   assign miso_w = miso_oe_o ? miso_o : (peer_master ? tog : peer_dout);
   assign peer_din = peer_master ? miso_w : mosi_w;

   always #5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) tog <= ~tog;

   spi_control_and_shift #(.FIFO_DEPTH(8)) u_spi_control_and_shift (
      .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_rdata_o(sfr_rdata_o), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
      .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w),
      .miso_o(miso_o), .miso_oe_o(miso_oe_o), .slave_select_n_i(peer_ss_n),
      .alternate_pin_select_i(alternate_pin_select_i), .two_wire_enable_o(two_wire_enable_o));

   spi_peer_model u_spi_peer_model (
      .core_clk_i(core_clk_i), .idle_level_select_i(pcpol), .edge_phase_select_i(pcpha), .sclk_i(sclk_w),
      .din_i(peer_din), .dout_o(peer_dout), .sclk_o(peer_sclk), .ss_n_o(peer_ss_n),
      .rx_o(peer_rx));

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Read data stands one cycle after the read edge
   always @(posedge core_clk_i) begin
      if (rd_d === 1'b1) begin
         if (exp_q.size() == 0) check(8'h00, 8'hff);
         else check(sfr_rdata_o, exp_q.pop_front());
      end
      rd_d <= sfr_rd_i;
   end

   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction

   // Each access leaves one idle edge so strobes never rise twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      sfr_wr_i = 1'b0;
      @(posedge core_clk_i);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      sfr_rd_i = 1'b0;
      @(posedge core_clk_i);
      #1;
   endtask

   task automatic burst(input int h, input int n_tog);
      int   cnt;
      int   gap;
      logic last;
      cnt = 0;
      gap = 0;
      last = sclk_o;
      repeat (16 * h + 8) begin
         @(posedge core_clk_i);
         #1;
         gap++;
         if (sclk_o !== last) begin
            if (cnt > 0) check(8'(gap), 8'(h));
            cnt++;
            gap = 0;
            last = sclk_o;
         end
      end
      check(8'(cnt), 8'(n_tog));
      check(sclk_o, pcpol);
   endtask

   task automatic xfer(input logic [3:0] m, input int n_tog, input logic coll);
      wr(spi_pkg::CTRL_ADDR, {4'h3, m});
      pcpol = m[3];
      pcpha = m[2];
      check(sclk_o, m[3]);
      check(sclk_oe_o, 1'b1);
      check(two_wire_enable_o, 1'b0);
      exp_tx[m] = rnd();
      exp_rx[m] = rnd();
      u_spi_peer_model.load(exp_rx[m]);
      wr(spi_pkg::DATA_ADDR, exp_tx[m]);
      if (coll) wr(spi_pkg::DATA_ADDR, rnd());
      burst(1 << m[1:0], n_tog);
      if (n_tog > 0) check(peer_rx, exp_tx[m]);
      rd(spi_pkg::CTRL_ADDR, {n_tog > 0, coll, 2'b11, m});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] tx;
      logic [7:0] b;
      repeat (12) @(posedge core_clk_i);
      #1;
      reset_n_i = 1'b1;
      rd(spi_pkg::CTRL_ADDR, 8'h05);
      check(two_wire_enable_o, 1'b1);
      wr(8'h00, 8'hff);
      wr(spi_pkg::CTRL_ADDR, 8'hc4);
      rd(spi_pkg::CTRL_ADDR, 8'h05);
      for (int k = 0; k < 8; k++) begin
         xfer(4'(k), 16, 1'b0);
         wr(spi_pkg::CTRL_ADDR, 8'h30 | 8'(k));
         rd(spi_pkg::CTRL_ADDR, 8'h30 | 8'(k));
      end
      // Buffer full: the ninth burst must wait for a pop
      xfer(4'h8, 0, 1'b0);
      rd(spi_pkg::DATA_ADDR, exp_rx[0]);
      burst(1, 16);
      check(peer_rx, exp_tx[8]);
      rd(spi_pkg::CTRL_ADDR, 8'hb8);
      for (int j = 1; j < 9; j++) rd(spi_pkg::DATA_ADDR, exp_rx[j]);
      rd(spi_pkg::DATA_ADDR, 8'h00);
      rd(spi_pkg::CTRL_ADDR, 8'h38);
      for (int k = 9; k < 16; k++) begin
         xfer(4'(k), 16, k == 11);
         rd(spi_pkg::DATA_ADDR, exp_rx[k]);
         rd(spi_pkg::CTRL_ADDR, {1'b0, k == 11, 2'b11, 4'(k)});
         wr(spi_pkg::CTRL_ADDR, 8'h30 | 8'(k));
      end
      rd(spi_pkg::CTRL_ADDR, 8'h3f);
      peer_master = 1'b1;
      for (int c = 0; c < 2; c++) begin
         pcpol = 1'b0;
         pcpha = c[0];
         wr(spi_pkg::CTRL_ADDR, {5'h04, c[0], 2'b00});
         rd(spi_pkg::CTRL_ADDR, {5'h04, c[0], 2'b01});
         check(sclk_oe_o, 1'b0);
         check(miso_oe_o, 1'b0);
         tx = rnd();
         b = rnd();
         u_spi_peer_model.load(b);
         wr(spi_pkg::DATA_ADDR, tx);
         u_spi_peer_model.master_xfer();
         repeat (6) @(posedge core_clk_i);
         #1;
         rd(spi_pkg::CTRL_ADDR, {5'h14, c[0], 2'b01});
         rd(spi_pkg::DATA_ADDR, b);
         check(peer_rx, tx);
      end
      wr(spi_pkg::CTRL_ADDR, 8'h00);
      check(two_wire_enable_o, 1'b1);
      wr(spi_pkg::DATA_ADDR, 8'h5a);
      rd(spi_pkg::CTRL_ADDR, 8'h01);
      wr(spi_pkg::CTRL_ADDR, 8'h30);
      alternate_pin_select_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      check(two_wire_enable_o, 1'b1);
      stop_test();
   end
endmodule // test_spi_control_and_shift

`default_nettype wire
